// *** src/operand_address_generation.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Literal mode operand comes from program bytes following the opcode.
// - Direct mode takes location from an 8-bit instruction address field.
// - Direct mode reaches low 128 RAM bytes and SFR space only.
// - Pointer mode reads address from named register; internal or external.
// - 8-bit pointers are bank slot zero, slot one, or stack pointer.
// - 16-bit pointers come only from the table pointer register.
// - Register mode decodes 3-bit opcode field selecting bank register.
// - Register mode fetches no extra address byte.
// - Register-specific mode puts the accumulator SFR (ACC_SFR_ADDR) on dataAddr but leaves dataValid low; no address byte.
// - Indexed mode reads program memory only; never writes.
// - Indexed read address is table pointer or PC plus accumulator.
// - Indexed jump loads PC with table pointer plus accumulator.
module operand_address_generation
	import operand_addr_pkg::*;
(
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       reset_n,
	// Decoder request
	input  wire operand_addr_pkg::request_type request,
	// Core state
	input  wire logic [1:0]                 bankSelect,
	input  wire logic [7:0]                 bankSlotZero,
	input  wire logic [7:0]                 bankSlotOne,
	input  wire logic [7:0]                 stackPointer,
	input  wire logic [15:0]                table_pointer,
	input  wire logic [15:0]                programCounter,
	input  wire logic [7:0]                 accumulator,
	// Formed location
	output operand_addr_pkg::result_type    result
);
	import operand_addr_pkg::*;

	result_type resultD;

	// One register group per concern, so each field has a single owner
	logic        valid_q;
	logic        refused_q;
	logic        literalValid_q;
	logic [7:0]  literalValue_q;
	logic        dataValid_q;
	logic [7:0]  dataAddr_q;
	logic        sfrSpace_q;
	logic        extValid_q;
	logic [15:0] extAddr_q;
	logic        codeRead_q;
	logic [15:0] codeAddr_q;
	logic        pcLoad_q;
	logic [15:0] pcNext_q;
	logic        fetchExtra_q;
	logic        writeAllowed_q;

	// Bank register address from the 3-bit opcode field
	function automatic logic [7:0] bankRegAddr(input logic [1:0] bank,
		input logic [2:0] slot);
		bankRegAddr = {3'h0, bank, slot};
	endfunction

	// Zero-extended add that drops the carry out of bit 15
	function automatic logic [15:0] indexSum(input logic [15:0] base,
		input logic [7:0] idx);
		logic [16:0] full;
		full = {1'b0, base} + {9'h000, idx};
		indexSum = full[15:0];
	endfunction

	logic [7:0] ptrByte;
	logic [15:0] indexBase;

	always_comb begin
		// Pointer register choice
		unique case (request.ptrSel)
			PTR_SLOT_ZERO: ptrByte = bankSlotZero;
			PTR_SLOT_ONE:  ptrByte = bankSlotOne;
			PTR_STACK:     ptrByte = stackPointer;
			PTR_TABLE:     ptrByte = table_pointer[7:0];
		endcase
		indexBase = request.baseIsPc ? programCounter : table_pointer;
	end

	always_comb begin
		resultD = '0;
		resultD.valid = request.valid;
		if (request.valid) begin
			unique case (request.mode)
				MODE_LITERAL: begin
					resultD.literalValid = 1'b1;
					resultD.literalValue = request.operandByte;
					resultD.fetchExtra = 1'b1;
					resultD.writeAllowed = 1'b0;
				end
				MODE_DIRECT: begin
					resultD.fetchExtra = 1'b1;
					resultD.dataValid = 1'b1;
					resultD.writeAllowed = request.writeReq;
					resultD.sfrSpace =
						(request.operandByte & SFR_SPACE_BIT) != 8'h00;
					resultD.dataAddr = request.operandByte;
				end
				MODE_POINTER: begin
					resultD.writeAllowed = request.writeReq;
					if (request.ptrSel == PTR_TABLE) begin
						resultD.extValid = 1'b1;
						resultD.extAddr = table_pointer;
					end else if (request.ptrExternal) begin
						resultD.extValid = 1'b1;
						resultD.extAddr = {8'h00, ptrByte};
					end else begin
						// slot zero, slot one or stack
						resultD.dataValid = 1'b1;
						resultD.dataAddr = ptrByte;
					end
				end
				MODE_REGISTER: begin
					resultD.dataValid = 1'b1;
					resultD.dataAddr =
						bankRegAddr(bankSelect, request.opcode[2:0]);
					resultD.writeAllowed = request.writeReq;
					resultD.fetchExtra = 1'b0;
				end
				MODE_SPECIFIC: begin
					resultD.fetchExtra = 1'b0;
					resultD.sfrSpace = 1'b1;
					resultD.dataAddr = ACC_SFR_ADDR;
					resultD.writeAllowed = request.writeReq;
				end
				MODE_INDEXED: begin
					resultD.writeAllowed = 1'b0;
					resultD.refused = request.writeReq;
					if (request.indexJump) begin
						resultD.pcLoad = 1'b1;
						resultD.pcNext = indexSum(table_pointer, accumulator);
					end else begin
						resultD.codeRead = 1'b1;
						resultD.codeAddr = indexSum(indexBase, accumulator);
					end
				end
				default: begin
					// Unknown or idle mode yields no access
					resultD.refused = 1'b1;
				end
			endcase
		end
	end

	// Acceptance and refusal
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			valid_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			valid_q <= resultD.valid;
			refused_q <= resultD.refused;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			literalValid_q <= 1'b0;
			literalValue_q <= 8'h00;
		end else begin
			literalValid_q <= resultD.literalValid;
			literalValue_q <= resultD.literalValue;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dataValid_q <= 1'b0;
			dataAddr_q <= 8'h00;
			sfrSpace_q <= 1'b0;
		end else begin
			dataValid_q <= resultD.dataValid;
			dataAddr_q <= resultD.dataAddr;
			sfrSpace_q <= resultD.sfrSpace;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			extValid_q <= 1'b0;
			extAddr_q <= 16'h0000;
		end else begin
			extValid_q <= resultD.extValid;
			extAddr_q <= resultD.extAddr;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			codeRead_q <= 1'b0;
			codeAddr_q <= 16'h0000;
		end else begin
			codeRead_q <= resultD.codeRead;
			codeAddr_q <= resultD.codeAddr;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pcLoad_q <= 1'b0;
			pcNext_q <= 16'h0000;
		end else begin
			pcLoad_q <= resultD.pcLoad;
			pcNext_q <= resultD.pcNext;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fetchExtra_q <= 1'b0;
			writeAllowed_q <= 1'b0;
		end else begin
			fetchExtra_q <= resultD.fetchExtra;
			writeAllowed_q <= resultD.writeAllowed;
		end
	end

	// Packed in field order of the result struct
	assign result = {valid_q, literalValid_q, literalValue_q, dataValid_q,
		dataAddr_q, sfrSpace_q, extValid_q, extAddr_q, codeRead_q,
		codeAddr_q, pcLoad_q, pcNext_q, fetchExtra_q, writeAllowed_q,
		refused_q};

endmodule

// *** src/operand_addr_pkg.sv ***
package operand_addr_pkg;

	localparam int DATA_W = 8;
	localparam int CODE_W = 16;
	localparam int DIRECT_LOW_LIMIT = 128;
	localparam logic [7:0] DIRECT_LOW_MASK = 8'h7f;
	localparam logic [7:0] SFR_SPACE_BIT = 8'h80;
	localparam logic [1:0] BANK_SEL_SHIFT = 2'h3;
	localparam logic [7:0] ACC_SFR_ADDR = 8'h00;

	// Addressing modes, one-hot
	typedef enum logic [6:0] {
		MODE_NONE     = 7'h01,
		MODE_LITERAL  = 7'h02,
		MODE_DIRECT   = 7'h04,
		MODE_POINTER  = 7'h08,
		MODE_REGISTER = 7'h10,
		MODE_SPECIFIC = 7'h20,
		MODE_INDEXED  = 7'h40
	} mode_type;

	// Pointer source for pointer mode
	typedef enum logic [1:0] {
		PTR_SLOT_ZERO = 2'h0,
		PTR_SLOT_ONE  = 2'h1,
		PTR_STACK     = 2'h2,
		PTR_TABLE     = 2'h3
	} ptr_sel_type;

	// Decoded request from the instruction decoder
	typedef struct packed {
		logic        valid;
		mode_type    mode;
		logic [7:0]  opcode;
		logic [7:0]  operandByte;
		ptr_sel_type ptrSel;
		logic        ptrExternal;
		logic        baseIsPc;
		logic        indexJump;
		logic        writeReq;
	} request_type;

	// Formed operand location
	typedef struct packed {
		logic        valid;
		logic        literalValid;
		logic [7:0]  literalValue;
		logic        dataValid;
		logic [7:0]  dataAddr;
		logic        sfrSpace;
		logic        extValid;
		logic [15:0] extAddr;
		logic        codeRead;
		logic [15:0] codeAddr;
		logic        pcLoad;
		logic [15:0] pcNext;
		logic        fetchExtra;
		logic        writeAllowed;
		logic        refused;
	} result_type;

endpackage

// *** verification/operand_sva.sv ***
`timescale 1ns/1ps
module operand_sva
	import operand_addr_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire request_type request,
	input wire logic [1:0]  bankSelect,
	input wire logic [7:0]  bankSlotOne,
	input wire logic [15:0] table_pointer,
	input wire logic [15:0] programCounter,
	input wire logic [7:0]  accumulator,
	input wire result_type  result
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire v = request.valid;
	mode_type m;
	logic [15:0] base;
	assign m = request.mode;
	assign base = request.baseIsPc ? programCounter : table_pointer;
	lit_val_a: assert property (v && m == MODE_LITERAL |=>
		result.literalValue == $past(request.operandByte)) else $error("lit");
	dir_addr_a: assert property (v && m == MODE_DIRECT |=>
		result.dataAddr == $past(request.operandByte) && result.fetchExtra &&
		result.sfrSpace == $past(request.operandByte[7])) else $error("dir");
	ptr_slot_a: assert property (v && m == MODE_POINTER &&
		request.ptrSel == PTR_SLOT_ONE && !request.ptrExternal |=>
		result.dataAddr == $past(bankSlotOne)) else $error("slot");
	ptr_wide_a: assert property (v && m == MODE_POINTER &&
		request.ptrSel == PTR_TABLE |=> result.extValid &&
		result.extAddr == $past(table_pointer)) else $error("wide");
	reg_slot_a: assert property (v && m == MODE_REGISTER |=>
		!result.fetchExtra && result.dataAddr == {3'h0, $past(bankSelect),
		$past(request.opcode[2:0])}) else $error("reg");
	spec_byte_a: assert property (v && m == MODE_SPECIFIC |=>
		!result.fetchExtra) else $error("spec");
	idx_read_a: assert property (v && m == MODE_INDEXED &&
		!request.indexJump |=> result.codeRead && !result.writeAllowed &&
		result.codeAddr == $past(base) + $past(accumulator)) else $error("idx");
	idx_jump_a: assert property (v && m == MODE_INDEXED &&
		request.indexJump |=> result.pcLoad && result.pcNext ==
		$past(table_pointer) + $past(accumulator)) else $error("jmp");
endmodule
bind operand_address_generation operand_sva operand_sva_i (.*);

// *** verification/mem_model.sv ***
`timescale 1ns/1ps
module mem_model
	import operand_addr_pkg::*;
(
	input  wire result_type result,
	output logic [7:0]      codeByte
);
	// Idle bus shows the inverse, never a stale good byte
	assign codeByte = {8{!result.codeRead}} ^ result.codeAddr[15:8]
		^ result.codeAddr[7:0];
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import operand_addr_pkg::*;
	logic        ref_clk = 0;
	logic        reset_n = 0;
	request_type request = '0;
	logic [1:0]  bankSelect = 0;
	logic [7:0]  bankSlotZero = 0, bankSlotOne = 0, stackPointer = 0;
	logic [7:0]  accumulator = 0, codeByte;
	logic [15:0] table_pointer = 0, programCounter = 0;
	result_type  result;
	logic [31:0] s = 32'h00009548;
	int          fails = 0, n_tests = 0;
	always #2.5 ref_clk = ~ref_clk;
	operand_address_generation operand_address_generation_i (
		.ref_clk(ref_clk), .reset_n(reset_n), .request(request),
		.bankSelect(bankSelect), .bankSlotZero(bankSlotZero),
		.bankSlotOne(bankSlotOne), .stackPointer(stackPointer),
		.table_pointer(table_pointer), .programCounter(programCounter),
		.accumulator(accumulator), .result(result));
	mem_model mem_model_i (.result(result), .codeByte(codeByte));
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [17:0] ex();
		logic [7:0] p;
		logic x;
		p = request.ptrSel == PTR_SLOT_ZERO ? bankSlotZero :
			request.ptrSel == PTR_SLOT_ONE ? bankSlotOne : stackPointer;
		x = request.ptrExternal | request.ptrSel == PTR_TABLE;
		case (request.mode)
		MODE_LITERAL: return {10'h0, request.operandByte};
		MODE_DIRECT: return {1'b1, request.operandByte[7], 8'h0,
			request.operandByte};
		MODE_POINTER: return {1'b1, x, request.ptrSel == PTR_TABLE ?
			table_pointer : {8'h0, p}};
		MODE_REGISTER: return {13'h0, bankSelect, request.opcode[2:0]};
		MODE_SPECIFIC: return 18'h10000;
		MODE_INDEXED: return {2'h2, (request.indexJump | !request.baseIsPc ?
			table_pointer : programCounter) + {8'h0, accumulator}};
		default: return 18'h20000;
		endcase
	endfunction
	function automatic logic [17:0] got(request_type q);
		case (q.mode)
		MODE_LITERAL: return {result.writeAllowed, 9'h0, result.literalValue};
		MODE_DIRECT, MODE_REGISTER, MODE_SPECIFIC: return {result.fetchExtra,
			result.sfrSpace, 8'h0, result.dataAddr};
		MODE_POINTER: return {result.extValid | result.dataValid,
			result.extValid, result.extValid ? result.extAddr :
			{8'h0, result.dataAddr}};
		MODE_INDEXED: return q.indexJump ? {result.pcLoad,
			result.writeAllowed, result.pcNext} : {result.codeRead,
			result.writeAllowed, result.codeAddr};
		default: return {result.refused, 17'h0};
		endcase
	endfunction
	function automatic logic [17:0] flags(request_type q);
		logic w;
		w = q.writeReq && (q.mode == MODE_DIRECT || q.mode == MODE_POINTER ||
			q.mode == MODE_REGISTER || q.mode == MODE_SPECIFIC);
		return {14'h0, 1'b1, q.mode == MODE_NONE ||
			(q.mode == MODE_INDEXED && q.writeReq), w,
			q.mode == MODE_LITERAL};
	endfunction
	task automatic cmp(logic [17:0] g, logic [17:0] x);
		n_tests++;
		if (g !== x) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic end_sim();
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		request_type q, pq;
		logic [31:0] t, u;
		logic [17:0] e;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 400; i++) begin
			@(posedge ref_clk);
			t = xs();
			u = xs();
			q = request_type'(xs());
			q.valid = 1'b1;
			q.mode = mode_type'(7'h01 << (t % 7));
			// Wrap of the table pointer base (both indexed cases draw a jump) and the low RAM/SFR split come first
			if (i < 4) q.mode = i[0] ? MODE_DIRECT : MODE_INDEXED;
			if (i < 4) q.operandByte = 8'h7f + 8'(i[7:1]);
			request <= q;
			bankSelect <= t[25:24];
			bankSlotZero <= t[7:0];
			bankSlotOne <= t[15:8];
			stackPointer <= u[31:24];
			table_pointer <= i < 4 ? 16'hffff : u[15:0];
			programCounter <= i < 4 ? 16'hfffe : t[31:16];
			accumulator <= i < 4 ? 8'h02 : u[23:16];
			@(negedge ref_clk);
			if (i > 0) cmp(got(pq), e);
			if (i > 0 && pq.mode == MODE_INDEXED && !pq.indexJump)
				cmp({10'h0, codeByte}, {10'h0, e[15:8] ^ e[7:0]});
			if (i > 0) cmp({14'h0, result.valid, result.refused,
				result.writeAllowed, result.literalValid}, flags(pq));
			e = ex();
			pq = request;
		end
		end_sim();
	end
endmodule
